// ===== rtl/ifeu_pkg.sv
/*
 * Constants for the interrupt flag and enable unit: register offsets,
 * source bit positions, control field layout, reset values and rates.
 * Assumes a 50 MHz sys_clk and a divider that makes the low-rate clock.
 */
package ifeu_pkg;
   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [7:0] ADDR_ENABLE = 8'h0c;
   localparam logic [7:0] ADDR_FLAGS = 8'h0d;
   localparam logic [7:0] ADDR_ROUTE = 8'h0e;
   localparam logic [7:0] ADDR_TICK_CTRL = 8'h0f;
   // ****************************************************************
   // Source bit positions
   // ****************************************************************
   localparam int NUM_SRC = 6;
   localparam int SRC_TIMER2 = 0;
   localparam int SRC_TIMER1 = 1;
   localparam int SRC_TIMER0 = 2;
   localparam int SRC_FAST = 3;
   localparam int SRC_SLOW = 4;
   localparam int SRC_EXT = 5;
   // ****************************************************************
   // Tick control fields and reset values
   // ****************************************************************
   localparam int FAST_SEL_LSB = 0;
   localparam int SLOW_SEL_LSB = 3;
   localparam int EDGE_BIT = 6;
   localparam logic [2:0] FAST_SEL_RST = 3'h3;
   localparam logic [2:0] SLOW_SEL_RST = 3'h0;
   localparam logic EDGE_RST = 1'b1;
   localparam logic [5:0] SRC_RST = 6'h00;
   // ****************************************************************
   // Divider chain: stages 0..13, low-rate clock 32768 Hz
   // ****************************************************************
   localparam int DIV_STAGES = 14;
   // Divider stage tapped by each fast tick code, code 0 first
   localparam int FAST_STAGE_C0 = 10;
   localparam int FAST_STAGE_C1 = 8;
   localparam int FAST_STAGE_C2 = 6;
   localparam int FAST_STAGE_C3 = 4;
   localparam int FAST_STAGE_C4 = 3;
   localparam int FAST_STAGE_C5 = 2;
   localparam int FAST_STAGE_C6 = 1;
   localparam int FAST_STAGE_C7 = 0;
   // Slow tick code 0 taps this stage, each higher code one lower
   localparam int SLOW_STAGE_C0 = 13;
   // Cycles after reset before the pin edge detector is trusted
   localparam logic [2:0] EXT_PRIME_LAST = 3'h4;
   localparam int SYS_HZ = 50000000;
   localparam int LOW_HZ = 32768;
   localparam int LOW_DIV = SYS_HZ / LOW_HZ;
   localparam logic [10:0] LOW_DIV_LAST = 11'(LOW_DIV - 1);
endpackage

// ===== rtl/ifeu_top.sv
/*
 * Interrupt flag and enable unit: six sticky flags, enables, routing
 * to ordinary or non-maskable request, and the real-time tick chain.
 * Registers sit on a plain strobe port: enables, flags (a written 0
 * clears, a written 1 keeps), routing and tick control; read data
 * follow one cycle after the read strobe and read zero otherwise.
 * Assumes timer events are one-cycle pulses on sys_clk and the
 * external pin is asynchronous; halt_mode comes from power control.
 * Assumes the low-rate clock may be made from sys_clk, so the tick
 * rates are nominal, and that the core takes level requests on
 * sys_clk.
 */
`timescale 1ns/10ps
module ifeu_top (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic timer2_evt,
   input wire logic timer1_evt,
   input wire logic timer0_evt,
   input wire logic ext_pin,
   input wire logic halt_mode,
   output logic irq_req,
   output logic nmi_req
);
   // ****************************************************************
   // Registers
   // ****************************************************************
   // Software-visible state
   logic [5:0] enable_q;
   logic [5:0] flags_q;
   logic [5:0] flags_d;
   logic [5:0] route_q;
   logic [2:0] fast_sel_q;
   logic [2:0] slow_sel_q;
   logic edge_rise_q;
   logic [7:0] rdata_d;
   logic irq_d;
   logic nmi_d;
   // Divider, pin and event nets
   logic [10:0] pre_q;
   logic [10:0] pre_d;
   logic low_tick;
   logic [13:0] div_q;
   logic [13:0] div_d;
   logic [2:0] ext_sync_q;
   logic ext_lvl_q;
   logic [2:0] ext_prime_q;
   logic ext_armed;
   logic [5:0] evt;
   logic fast_evt;
   logic slow_evt;
   logic ext_evt;
   logic wr_en;
   logic hit_enable;
   logic hit_flags;
   logic hit_route;
   logic hit_tick;

   // Tap stage for the fast tick; the low codes skip stages on purpose
   // so that eight codes spread over stages 10 down to 0
   function automatic int fast_stage(input logic [2:0] sel);
      unique case (sel)
         3'h0: fast_stage = ifeu_pkg::FAST_STAGE_C0;
         3'h1: fast_stage = ifeu_pkg::FAST_STAGE_C1;
         3'h2: fast_stage = ifeu_pkg::FAST_STAGE_C2;
         3'h3: fast_stage = ifeu_pkg::FAST_STAGE_C3;
         3'h4: fast_stage = ifeu_pkg::FAST_STAGE_C4;
         3'h5: fast_stage = ifeu_pkg::FAST_STAGE_C5;
         3'h6: fast_stage = ifeu_pkg::FAST_STAGE_C6;
         3'h7: fast_stage = ifeu_pkg::FAST_STAGE_C7;
      endcase
   endfunction

   // Tap stage for the slow tick: one stage per code, counting down
   function automatic int slow_stage(input logic [2:0] sel);
      slow_stage = ifeu_pkg::SLOW_STAGE_C0 - int'(sel);
   endfunction

   // Address match, shared by every write process
   function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
      addr_hit = (addr == target);
   endfunction

   assign wr_en = reg_wr;

   // Register selects
   assign hit_enable = addr_hit(reg_addr, ifeu_pkg::ADDR_ENABLE);
   assign hit_flags = addr_hit(reg_addr, ifeu_pkg::ADDR_FLAGS);
   assign hit_route = addr_hit(reg_addr, ifeu_pkg::ADDR_ROUTE);
   assign hit_tick = addr_hit(reg_addr, ifeu_pkg::ADDR_TICK_CTRL);

   // ****************************************************************
   // Real-time divider chain
   // ****************************************************************
   // The prescaler stands in for the low-rate oscillator; its period is
   // the truncated clock ratio, so the ticks run a little fast
   always_comb begin
      if (pre_q == ifeu_pkg::LOW_DIV_LAST) begin
         pre_d = 11'h000;
      end else begin
         pre_d = pre_q + 11'h001;
      end
   end

   // Frozen in halt, as the low-rate clock is stopped there
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pre_q <= 11'h000;
      end else if (!halt_mode) begin
         pre_q <= pre_d;
      end
   end

   assign low_tick = !halt_mode && (pre_q == ifeu_pkg::LOW_DIV_LAST);

   // Binary count; stage n toggles at low_rate/2^(n+1), so it rises
   // once every 2^(n+1) low ticks
   always_comb begin
      div_d = div_q + 14'h0001;
   end

   // Counter advances once per low tick only
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         div_q <= 14'h0000;
      end else if (low_tick) begin
         div_q <= div_d;
      end
   end

   // ****************************************************************
   // Tick events
   // ****************************************************************
   // Tick fires on rising edge of the selected stage; a tap change is
   // only looked at on a low tick, never between two of them
   always_comb begin
      fast_evt = low_tick && !div_q[fast_stage(fast_sel_q)]
                 && div_d[fast_stage(fast_sel_q)];
      slow_evt = low_tick && !div_q[slow_stage(slow_sel_q)]
                 && div_d[slow_stage(slow_sel_q)];
   end

   // ****************************************************************
   // External pin
   // ****************************************************************
   // Three stages; the first feeds only the second
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ext_sync_q <= 3'h0;
      end else begin
         ext_sync_q <= {ext_sync_q[1:0], ext_pin};
      end
   end

   // Settled pin level, taken only when the last two stages agree
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ext_lvl_q <= 1'b0;
      end else if (ext_sync_q[1] == ext_sync_q[2]) begin
         ext_lvl_q <= ext_sync_q[2];
      end
   end

   // Hold the detector off until the chain holds real pin samples, so a
   // pin idling high gives no false edge; an edge this early is lost
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ext_prime_q <= 3'h0;
      end else if (!ext_armed) begin
         ext_prime_q <= ext_prime_q + 3'h1;
      end
   end

   assign ext_armed = (ext_prime_q == ifeu_pkg::EXT_PRIME_LAST);

   // Edge only on an agreed change, so a glitch counts once at most
   assign ext_evt = ext_armed && (ext_sync_q[1] == ext_sync_q[2])
                    && (ext_sync_q[2] != ext_lvl_q)
                    && (ext_sync_q[2] == edge_rise_q);

   // ****************************************************************
   // Sources
   // ****************************************************************
   // Source gathering: bit order matches the enable, flag and routing
   // registers, timer2 at the bottom and the pin at the top
   always_comb begin
      evt = 6'h00;
      evt[ifeu_pkg::SRC_TIMER2] = timer2_evt;
      evt[ifeu_pkg::SRC_TIMER1] = timer1_evt;
      evt[ifeu_pkg::SRC_TIMER0] = timer0_evt;
      evt[ifeu_pkg::SRC_FAST] = fast_evt;
      evt[ifeu_pkg::SRC_SLOW] = slow_evt;
      evt[ifeu_pkg::SRC_EXT] = ext_evt;
   end

   // ****************************************************************
   // Software registers
   // ****************************************************************
   // Enable bits; a disabled source still sets its flag for polling
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         enable_q <= ifeu_pkg::SRC_RST;
      end else if (wr_en && hit_enable) begin
         enable_q <= reg_wdata[5:0];
      end
   end

   // Routing bits; reset sends every source to the ordinary line
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         route_q <= ifeu_pkg::SRC_RST;
      end else if (wr_en && hit_route) begin
         route_q <= reg_wdata[5:0];
      end
   end

   // Tick taps and pin edge polarity
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         fast_sel_q <= ifeu_pkg::FAST_SEL_RST;
         slow_sel_q <= ifeu_pkg::SLOW_SEL_RST;
         edge_rise_q <= ifeu_pkg::EDGE_RST;
      end else if (wr_en && hit_tick) begin
         fast_sel_q <= reg_wdata[ifeu_pkg::FAST_SEL_LSB +: 3];
         slow_sel_q <= reg_wdata[ifeu_pkg::SLOW_SEL_LSB +: 3];
         edge_rise_q <= reg_wdata[ifeu_pkg::EDGE_BIT];
      end
   end

   // ****************************************************************
   // Interrupt flags
   // ****************************************************************
   // Written 0 clears, written 1 keeps; an event in the cycle of its
   // own clear wins, so no event is ever lost
   always_comb begin
      flags_d = flags_q | evt;
      if (wr_en && hit_flags) begin
         flags_d = (flags_q & reg_wdata[5:0]) | evt;
      end
   end

   // Sticky flags
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         flags_q <= ifeu_pkg::SRC_RST;
      end else begin
         flags_q <= flags_d;
      end
   end

   // ****************************************************************
   // Read port
   // ****************************************************************
   // Read data select; unmapped addresses and idle cycles read zero
   always_comb begin
      rdata_d = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            ifeu_pkg::ADDR_ENABLE: rdata_d = {2'h0, enable_q};
            ifeu_pkg::ADDR_FLAGS: rdata_d = {2'h0, flags_q};
            ifeu_pkg::ADDR_ROUTE: rdata_d = {2'h0, route_q};
            ifeu_pkg::ADDR_TICK_CTRL: rdata_d = {1'b0, edge_rise_q, slow_sel_q, fast_sel_q};
            default: rdata_d = 8'h00;
         endcase
      end
   end

   // Read data, one cycle after the strobe and only then
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= rdata_d;
      end
   end

   // ****************************************************************
   // Requests to the core
   // ****************************************************************
   // Split pending sources by routing; a source sent to the
   // non-maskable line never shows on the ordinary one
   always_comb begin
      irq_d = |(flags_q & enable_q & ~route_q);
      nmi_d = |(flags_q & enable_q & route_q);
   end

   // Registered so the outputs come straight from flip-flops, at the
   // cost of one cycle between a flag and its request
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         irq_req <= 1'b0;
         nmi_req <= 1'b0;
      end else begin
         irq_req <= irq_d;
         nmi_req <= nmi_d;
      end
   end
endmodule

// ===== tb/ifeu_chk_sva.sv
/* Port checker for ifeu_top.
   Assumes a shadow of enables and routing mirrors the register writes. */
`timescale 1ns/10ps
module ifeu_chk (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic timer2_evt,
   input wire logic irq_req,
   input wire logic nmi_req
);
   // ****
   // Shadows, since the checker cannot see inside
   // ****
   logic [5:0] en_q;
   logic [5:0] route_sh_q;
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   // Enable shadow
   always_ff @(posedge sys_clk) begin
      if (!rst_n) en_q <= 6'h00;
      else if (reg_wr && reg_addr == 8'h0c) en_q <= reg_wdata[5:0];
   end
   // Routing shadow
   always_ff @(posedge sys_clk) begin
      if (!rst_n) route_sh_q <= 6'h00;
      else if (reg_wr && reg_addr == 8'h0e) route_sh_q <= reg_wdata[5:0];
   end
   a_rd_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero");
   a_en_readback: assert property ($past(reg_rd) && $past(reg_addr) == 8'h0c
      |-> reg_rdata == {2'h0, $past(en_q)}) else $error("enable readback wrong");
   a_flag_top_zero: assert property ($past(reg_rd) && $past(reg_addr) == 8'h0d
      |-> reg_rdata[7:6] == 2'h0) else $error("flag top bits set");
   a_req_needs_en: assert property (en_q == 6'h00 |=> !irq_req && !nmi_req)
      else $error("request without enable");
   a_route_irq_only: assert property (route_sh_q == 6'h00 |=> !nmi_req)
      else $error("nmi without routing");
   a_timer_to_irq: assert property (timer2_evt && !reg_wr && en_q[0] && !route_sh_q[0]
      |-> ##2 irq_req) else $error("timer event gave no irq");
   a_timer_to_nmi: assert property (timer2_evt && !reg_wr && en_q[0] && route_sh_q[0]
      |-> ##2 nmi_req) else $error("timer event gave no nmi");
   a_req_sticky: assert property (irq_req && !$past(reg_wr) |=> irq_req)
      else $error("irq dropped without write");
   c_irq: cover property ($rose(irq_req));
   c_nmi: cover property ($rose(nmi_req));
   c_flag_rd: cover property (reg_rd && reg_addr == 8'h0d);
endmodule
bind ifeu_top ifeu_chk u_chk (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .timer2_evt, .irq_req, .nmi_req);

// ===== tb/ifeu_core_model.sv
/* Core model: counts request entries.
   Assumes level requests on sys_clk; the handler clears flags itself. */
`timescale 1ns/10ps
module ifeu_core_model (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic irq_req,
   input wire logic nmi_req,
   output int irq_cnt,
   output int nmi_cnt
);
   // ****
   // Entry counting
   // ****
   logic irq_q;
   logic nmi_q;
   // A rising request is one entry
   always @(posedge sys_clk) begin
      irq_q <= rst_n && irq_req;
      nmi_q <= rst_n && nmi_req;
      irq_cnt <= !rst_n ? 0 : irq_cnt + int'(irq_req && !irq_q);
      nmi_cnt <= !rst_n ? 0 : nmi_cnt + int'(nmi_req && !nmi_q);
   end
endmodule

// ===== tb/interrupt_flag_enable_unit_bench.sv
/* Bench for ifeu_top: register port, events, requests.
   Assumes a 50 MHz clock; ticks frozen by halt until the tick test. */
`timescale 1ns/10ps
module interrupt_flag_enable_unit_bench;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic [2:0] tmr = 3'h0;
   logic ext_pin = 1'b0;
   logic halt_mode = 1'b1;
   logic irq_req;
   logic nmi_req;
   int irq_cnt;
   int nmi_cnt;
   int bad_count = 0;
   int compares = 0;
   // ****
   // Clock, unit and core
   // ****
   always #10 sys_clk = ~sys_clk;
   ifeu_top dut (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .timer2_evt(tmr[0]), .timer1_evt(tmr[1]), .timer0_evt(tmr[2]), .ext_pin,
      .halt_mode, .irq_req, .nmi_req);
   ifeu_core_model core (.sys_clk, .rst_n, .irq_req, .nmi_req, .irq_cnt, .nmi_cnt);
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk("read data", exp, reg_rdata);
   endtask
   task automatic pulse(input logic [2:0] m);
      @(posedge sys_clk);
      tmr <= m;
      @(posedge sys_clk);
      tmr <= 3'h0;
   endtask
   task automatic req(input logic [7:0] exp);
      @(posedge sys_clk);
      #1 chk("requests", exp, {6'h0, irq_req, nmi_req});
   endtask
   // ****
   // Scenarios
   // ****
   task automatic t_reset();
      rd(8'h0c, 8'h00);
      rd(8'h0d, 8'h00);
      rd(8'h0e, 8'h00);
      rd(8'h0f, 8'h43);
      rd(8'h10, 8'h00);
   endtask
   // Polling with enables off; clear one flag, then all
   task automatic t_poll();
      pulse(3'h7);
      rd(8'h0d, 8'h07);
      req(8'h00);
      wr(8'h0d, 8'h3e);
      rd(8'h0d, 8'h06);
      wr(8'h0d, 8'h00);
      rd(8'h0d, 8'h00);
      // Event in the very cycle of its clear: the set wins
      @(posedge sys_clk);
      tmr <= 3'h1;
      reg_addr <= 8'h0d;
      reg_wdata <= 8'h00;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      tmr <= 3'h0;
      reg_wr <= 1'b0;
      rd(8'h0d, 8'h01);
      wr(8'h0d, 8'h00);
   endtask
   task automatic t_route();
      wr(8'h0c, 8'hff);
      rd(8'h0c, 8'h3f);
      wr(8'h0e, 8'h01);
      pulse(3'h1);
      req(8'h01);
      wr(8'h0d, 8'h00);
      wr(8'h0e, 8'h00);
      pulse(3'h1);
      req(8'h02);
      wr(8'h0d, 8'h00);
      req(8'h00);
      chk("nmi entries", 8'h01, nmi_cnt[7:0]);
      chk("irq entries", 8'h01, irq_cnt[7:0]);
   endtask
   task automatic t_ext(input logic lvl, input logic [7:0] exp);
      @(posedge sys_clk);
      ext_pin <= lvl;
      repeat (8) @(posedge sys_clk);
      rd(8'h0d, exp);
      wr(8'h0d, 8'h00);
   endtask
   // Fastest tick raises a request; halt freezes it
   task automatic t_tick();
      int n;
      n = 0;
      wr(8'h0c, 8'h08);
      halt_mode <= 1'b0;
      while (irq_req !== 1'b1 && n < 3400) begin
         @(posedge sys_clk);
         #1 n++;
      end
      req(8'h02);
      halt_mode <= 1'b1;
      wr(8'h0d, 8'h00);
      repeat (7000) @(posedge sys_clk);
      rd(8'h0d, 8'h00);
   endtask
   task automatic stop_test();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Watchdog, about three times the expected run
   initial begin
      repeat (25000) @(posedge sys_clk);
      bad_count++;
      stop_test();
   end
   initial begin
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_reset();
      t_poll();
      t_route();
      t_ext(1'b1, 8'h20);
      wr(8'h0f, 8'h07);
      rd(8'h0f, 8'h07);
      t_ext(1'b0, 8'h20);
      t_ext(1'b1, 8'h00);
      t_tick();
      stop_test();
   end
endmodule
